// ---- core/rtpm_dev.sv ----
// touch panel measurement device: serial slave, driver switching, conversion timing
// ------------------------------------------------------------
// Summary of operation
// R1: device is a slave; host clocks everything
// R2: host writes command byte; device sequences it
// R3: Y measure: drive y plates, sense x_plate_pos
// R4: X measure: drive x plates, sense other plate
// R5: drivers-only command holds drivers until conversion
// R6: host waits for settling before converting
// R7: two cross-panel measurements, first and second
// R8: pressure from X, Y and cross_panel_first
// R9: 8-bit cycle: 40 serial, 127 conversion clocks
// R10: 12-bit cycle: 49 serial, 148 conversion clocks
// R11: resolution bit set: 8 bits, 4MHz clock
// R12: result held, read out most significant first
// ------------------------------------------------------------
`default_nettype none

module rtpm_dev
   import rtpm_pkg::*;
#(
   parameter int unsigned DIV_8 = CONV_DIV_8,
   parameter int unsigned DIV_12 = CONV_DIV_12,
   parameter int unsigned TICKS_8 = CONV_TICKS_8,
   parameter int unsigned TICKS_12 = CONV_TICKS_12
) (
   input wire logic clk,              // system clock
   input wire logic rst_b,            // synchronous reset
   rtpm_if.dev bus,                   // serial link
   input wire logic [11:0] adc_data,  // converter output, read at sample
   output logic adc_sample,           // converter result taken
   output logic [3:0] drv_en,         // drivers {x_pos, x_neg, y_pos, y_neg}
   output rtpm_mux_t adc_mux,         // plate routed to converter
   output logic busy,                 // conversion running
   output logic res8                  // 8-bit resolution selected
);

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_AACK = 3'h2,
      S_CMD = 3'h3,
      S_CACK = 3'h4,
      S_TX = 3'h5,
      S_MACK = 3'h6
   } rtpm_sstate_t;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // route for one measurement: {drivers, converter input}
   function automatic logic [5:0] meas_route(input logic [1:0] sel);
      logic [5:0] r;
      r = {DRV_OFF, RTPM_MUX_X_POS};
      unique case (sel)
         2'h0: r = {DRV_X_PLATE, RTPM_MUX_Y_POS}; // R4
         2'h1: r = {DRV_Y_PLATE, RTPM_MUX_X_POS}; // R3
         2'h2: r = {DRV_CROSS, RTPM_MUX_X_POS}; // R7 R8
         2'h3: r = {DRV_CROSS, RTPM_MUX_Y_NEG}; // R7
      endcase
      return r;
   endfunction

   // read bytes: high byte first, low nibble then padding
   function automatic logic [7:0] tx_byte(input logic idx, input logic [11:0] res);
      return idx ? {res[3:0], 4'h0} : res[11:4];
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= bus.scl_i;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= bus.sda_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   logic rise, fall, start, stop;
   assign rise = scl_s & ~scl_d;
   assign fall = ~scl_s & scl_d;
   assign start = scl_s & scl_d & sda_d & ~sda_s;
   assign stop = scl_s & scl_d & ~sda_d & sda_s;

   // ------------------------------------------------------------
   // serial slave
   // ------------------------------------------------------------
   rtpm_sstate_t s_reg, s_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic rw_reg, rw_next;
   logic pull_reg, pull_next;
   logic idx_reg, idx_next;
   logic mack_reg, mack_next;
   logic [7:0] cmd_reg, cmd_next;
   logic stb_reg, stb_next;
   logic [11:0] result_reg;
   logic [7:0] first_tx;
   logic [7:0] second_tx;

   assign first_tx = tx_byte(1'b0, result_reg);
   assign second_tx = tx_byte(1'b1, result_reg);

   // only ever answers the host's clock, never drives it R1
   always_comb begin
      s_next = s_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      rw_next = rw_reg;
      pull_next = pull_reg;
      idx_next = idx_reg;
      mack_next = mack_reg;
      cmd_next = cmd_reg;
      stb_next = 1'b0;
      if (start) begin
         s_next = S_ADDR;
         cnt_next = 4'h0;
         pull_next = 1'b0;
      end else if (stop) begin
         s_next = S_IDLE;
         pull_next = 1'b0;
      end else begin
         unique case (s_reg)
            S_IDLE: begin
               pull_next = 1'b0;
            end
            S_ADDR, S_CMD: begin
               if (rise) begin
                  sh_next = {sh_reg[6:0], sda_s};
                  cnt_next = cnt_reg + 4'h1;
               end else if (fall && cnt_reg == 4'h8) begin
                  cnt_next = 4'h0;
                  if (s_reg == S_CMD) begin
                     cmd_next = sh_reg; // R2
                     stb_next = 1'b1;
                     pull_next = 1'b1;
                     s_next = S_CACK;
                  end else if (sh_reg[7:1] == DEV_ADDR) begin
                     rw_next = sh_reg[0];
                     pull_next = 1'b1;
                     s_next = S_AACK;
                  end else begin
                     s_next = S_IDLE;
                  end
               end
            end
            S_AACK: begin
               if (fall) begin
                  if (rw_reg) begin
                     // held result goes out most significant bit first R12
                     idx_next = 1'b0;
                     sh_next = first_tx;
                     pull_next = ~first_tx[7];
                     s_next = S_TX;
                  end else begin
                     pull_next = 1'b0;
                     s_next = S_CMD;
                  end
               end
            end
            S_CACK: begin
               if (fall) begin
                  pull_next = 1'b0;
                  s_next = S_CMD;
               end
            end
            S_TX: begin
               if (rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (fall) begin
                  if (cnt_reg == 4'h8) begin
                     cnt_next = 4'h0;
                     pull_next = 1'b0;
                     s_next = S_MACK;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     pull_next = ~sh_reg[6]; // R12
                  end
               end
            end
            S_MACK: begin
               if (rise) begin
                  mack_next = ~sda_s;
               end else if (fall) begin
                  // one byte in 8-bit mode, two otherwise R11
                  if (mack_reg && !idx_reg && !res8) begin
                     idx_next = 1'b1;
                     sh_next = second_tx;
                     pull_next = ~second_tx[7];
                     s_next = S_TX;
                  end else begin
                     pull_next = 1'b0;
                     s_next = S_IDLE;
                  end
               end
            end
            default: begin
               s_next = S_IDLE;
               pull_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_reg <= S_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         rw_reg <= 1'b0;
         pull_reg <= 1'b0;
         idx_reg <= 1'b0;
         mack_reg <= 1'b0;
         cmd_reg <= 8'h00;
         stb_reg <= 1'b0;
      end else begin
         s_reg <= s_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         rw_reg <= rw_next;
         pull_reg <= pull_next;
         idx_reg <= idx_next;
         mack_reg <= mack_next;
         cmd_reg <= cmd_next;
         stb_reg <= stb_next;
      end
   end

   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = pull_reg;

   // ------------------------------------------------------------
   // driver switching and conversion timing
   // ------------------------------------------------------------
   logic [3:0] drv_next;
   rtpm_mux_t mux_next;
   logic busy_next, res8_next, sample_next;
   logic [7:0] div_reg, div_next;
   logic [7:0] tck_reg, tck_next;
   logic [11:0] result_next;
   logic [3:0] fn;
   // divider is wider than the defaults need so slower conversion clocks still fit
   logic [7:0] div_last;
   logic [7:0] tck_last;
   logic [5:0] route;

   assign fn = cmd_reg[CMD_FN_MSB:CMD_FN_LSB];
   assign route = meas_route(fn[1:0]);
   // conversion clock is an enable at the divided rate, twice as fast in 8-bit mode R11
   assign div_last = res8 ? 8'(DIV_8 - 1) : 8'(DIV_12 - 1);
   assign tck_last = res8 ? 8'(TICKS_8 - 1) : 8'(TICKS_12 - 1); // R9 R10

   always_comb begin
      drv_next = drv_en;
      mux_next = adc_mux;
      busy_next = busy;
      res8_next = res8;
      div_next = div_reg;
      tck_next = tck_reg;
      result_next = result_reg;
      sample_next = 1'b0;
      if (busy) begin
         div_next = div_reg + 8'h01;
         if (div_reg == div_last) begin
            div_next = 8'h00;
            tck_next = tck_reg + 8'h01;
            if (tck_reg == tck_last) begin
               busy_next = 1'b0;
               sample_next = 1'b1;
               drv_next = DRV_OFF;
               result_next = res8 ? {adc_data[11:4], 4'h0} : adc_data; // R12
            end
         end
      end
      // settling between drivers-only and conversion is left to the host R6
      if (stb_reg && fn[FN_VALID_BIT]) begin
         drv_next = route[5:2]; // R3 R4 R5
         mux_next = rtpm_mux_t'(route[1:0]);
         busy_next = fn[FN_CONV_BIT];
         res8_next = cmd_reg[CMD_RES_BIT]; // R11
         div_next = 8'h00;
         tck_next = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         drv_en <= DRV_OFF;
         adc_mux <= RTPM_MUX_X_POS;
         busy <= 1'b0;
         res8 <= 1'b0;
         div_reg <= 8'h00;
         tck_reg <= 8'h00;
         result_reg <= 12'h000;
         adc_sample <= 1'b0;
      end else begin
         drv_en <= drv_next;
         adc_mux <= mux_next;
         busy <= busy_next;
         res8 <= res8_next;
         div_reg <= div_next;
         tck_reg <= tck_next;
         result_reg <= result_next;
         adc_sample <= sample_next;
      end
   end

endmodule

`default_nettype wire

// ---- core/rtpm_pkg.sv ----
// constants and types shared by both ends of the touch panel measurement link
`default_nettype none

package rtpm_pkg;

   // ------------------------------------------------------------
   // clocks and timing
   // ------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ = 25_000_000;
   localparam int unsigned CONV_HZ_8 = 4_000_000;
   localparam int unsigned CONV_HZ_12 = CONV_HZ_8 / 2;
   // conversion clock periods in system cycles (period rounds down)
   localparam int unsigned CONV_DIV_8 = SYS_CLK_HZ / CONV_HZ_8;
   localparam int unsigned CONV_DIV_12 = SYS_CLK_HZ / CONV_HZ_12;
   // conversion clock periods spent per acquisition
   localparam int unsigned CONV_TICKS_8 = 127;
   localparam int unsigned CONV_TICKS_12 = 148;
   // serial clock periods spent per acquisition (write plus read)
   localparam int unsigned SCL_PER_ACQ_8 = 40;
   localparam int unsigned SCL_PER_ACQ_12 = 49;
   // host serial clock; a quarter period rounds up so the clock is never fast
   localparam int unsigned HOST_SCL_HZ = 400_000;
   localparam int unsigned HOST_QTR_CYCLES = (SYS_CLK_HZ + 4 * HOST_SCL_HZ - 1) / (4 * HOST_SCL_HZ);

   // ------------------------------------------------------------
   // addressing and command byte
   // ------------------------------------------------------------
   // slave address: arbitrary value
   localparam logic [6:0] DEV_ADDR = 7'h4A;
   localparam int unsigned CMD_FN_MSB = 7;
   localparam int unsigned CMD_FN_LSB = 4;
   localparam int unsigned CMD_RES_BIT = 1;
   localparam int unsigned FN_VALID_BIT = 3;
   localparam int unsigned FN_CONV_BIT = 2;
   localparam logic [3:0] FN_DRV_X = 4'h8;
   localparam logic [3:0] FN_DRV_Y = 4'h9;
   localparam logic [3:0] FN_DRV_Z1 = 4'hA;
   localparam logic [3:0] FN_DRV_Z2 = 4'hB;
   localparam logic [3:0] FN_MEAS_X = 4'hC;
   localparam logic [3:0] FN_MEAS_Y = 4'hD;
   localparam logic [3:0] FN_MEAS_Z1 = 4'hE;
   localparam logic [3:0] FN_MEAS_Z2 = 4'hF;

   // ------------------------------------------------------------
   // panel drivers {x_pos, x_neg, y_pos, y_neg} and converter input
   // ------------------------------------------------------------
   localparam logic [3:0] DRV_OFF = 4'h0;
   localparam logic [3:0] DRV_X_PLATE = 4'hC;
   localparam logic [3:0] DRV_Y_PLATE = 4'h3;
   localparam logic [3:0] DRV_CROSS = 4'h6;

   typedef enum logic [1:0] {
      RTPM_MUX_X_POS = 2'h0,
      RTPM_MUX_Y_POS = 2'h1,
      RTPM_MUX_Y_NEG = 2'h2
   } rtpm_mux_t;

endpackage

`default_nettype wire

// ---- core/rtpm_if.sv ----
// two-wire serial link between the host and the measurement device
`default_nettype none

interface rtpm_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl_i;
   logic sda_i;

   // open-drain wires with pull-ups: any driver pulling low wins
   assign scl_i = ~(host_scl_oe & ~host_scl_o);
   assign sda_i = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport host (
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe,
      input scl_i,
      input sda_i
   );

   modport dev (
      output dev_sda_o,
      output dev_sda_oe,
      input scl_i,
      input sda_i
   );
endinterface

`default_nettype wire

// ---- core/rtpm_host.sv ----
// serial bus master that writes command bytes and reads results
`default_nettype none

module rtpm_host
   import rtpm_pkg::*;
#(
   parameter int unsigned QTR = HOST_QTR_CYCLES
) (
   input wire logic clk,           // system clock
   input wire logic rst_b,         // synchronous reset
   rtpm_if.host bus,               // serial link
   input wire logic wr_req,        // write wr_cmd to the device
   input wire logic [7:0] wr_cmd,  // command byte
   input wire logic rd_req,        // read the result
   input wire logic rd_two,        // read two bytes instead of one
   output logic ready,             // idle, requests taken
   output logic done,              // transfer finished
   output logic nack,              // device refused a byte
   output logic [15:0] rd_data     // bytes read, last byte low, first of two high
);

   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_START = 2'h1,
      H_BIT = 2'h2,
      H_STOP = 2'h3
   } rtpm_hstate_t;

   rtpm_hstate_t st_reg, st_next;
   logic [7:0] q_reg, q_next;
   logic [1:0] ph_reg, ph_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] cmd_reg, cmd_next;
   logic rdop_reg, rdop_next;
   logic [1:0] frm_reg, frm_next;
   logic [1:0] last_reg, last_next;
   logic scl_pull_reg, scl_pull_next;
   logic sda_pull_reg, sda_pull_next;
   logic [15:0] data_reg, data_next;
   logic [15:0] rd_data_next;
   logic nack_next;
   logic done_next;
   logic sda_m, sda_s;
   logic tick;
   logic reading;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         sda_m <= bus.sda_i;
         sda_s <= sda_m;
      end
   end

   assign tick = (q_reg == 8'(QTR - 1));
   assign reading = rdop_reg & (frm_reg != 2'h0);
   assign ready = (st_reg == H_IDLE);

   // ------------------------------------------------------------
   // bit engine: four quarter phases per serial clock
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      q_next = tick ? 8'h00 : q_reg + 8'h01;
      ph_next = ph_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      cmd_next = cmd_reg;
      rdop_next = rdop_reg;
      frm_next = frm_reg;
      last_next = last_reg;
      scl_pull_next = scl_pull_reg;
      sda_pull_next = sda_pull_reg;
      data_next = data_reg;
      rd_data_next = rd_data;
      nack_next = nack;
      done_next = 1'b0;
      unique case (st_reg)
         H_IDLE: begin
            q_next = 8'h00;
            ph_next = 2'h0;
            frm_next = 2'h0;
            if (wr_req || rd_req) begin
               // the host alone makes the serial clock and every shift R1
               st_next = H_START;
               rdop_next = ~wr_req;
               cmd_next = wr_cmd;
               sh_next = {DEV_ADDR, ~wr_req};
               last_next = (!wr_req && rd_two) ? 2'h2 : 2'h1;
               nack_next = 1'b0;
               data_next = 16'h0000;
               sda_pull_next = 1'b1;
            end
         end
         H_START: begin
            if (tick) begin
               ph_next = 2'h1;
               scl_pull_next = 1'b1;
               if (ph_reg == 2'h1) begin
                  st_next = H_BIT;
                  ph_next = 2'h0;
                  bit_next = 4'h0;
                  sda_pull_next = ~sh_reg[7];
               end
            end
         end
         H_BIT: begin
            if (tick) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == 2'h1) begin
                  scl_pull_next = 1'b0;
               end
               if (ph_reg == 2'h3) begin
                  scl_pull_next = 1'b1;
                  bit_next = bit_reg + 4'h1;
                  if (bit_reg < 4'h8) begin
                     sh_next = {sh_reg[6:0], reading & sda_s};
                  end else if (!reading && sda_s) begin
                     nack_next = 1'b1;
                  end
                  if (bit_reg == 4'h8) begin
                     if (reading) begin
                        data_next = {data_reg[7:0], sh_reg};
                     end
                     if (frm_reg == last_reg || (!reading && sda_s)) begin
                        st_next = H_STOP;
                        ph_next = 2'h0;
                        sda_pull_next = 1'b1;
                     end else begin
                        // the command byte goes into the device's command register R2
                        frm_next = frm_reg + 2'h1;
                        bit_next = 4'h0;
                        sh_next = rdop_reg ? 8'h00 : cmd_reg;
                        sda_pull_next = ~rdop_reg & ~cmd_reg[7];
                     end
                  end else if (bit_reg == 4'h7) begin
                     // acknowledge every byte but the last one read
                     sda_pull_next = reading & (frm_reg != last_reg);
                  end else begin
                     sda_pull_next = ~reading & ~sh_reg[6];
                  end
               end
            end
         end
         H_STOP: begin
            if (tick) begin
               ph_next = ph_reg + 2'h1;
               // clock stays low two quarters, as in every bit, so the slave's late data release fits
               if (ph_reg == 2'h1) begin
                  scl_pull_next = 1'b0;
               end
               if (ph_reg == 2'h2) begin
                  sda_pull_next = 1'b0;
               end
               if (ph_reg == 2'h3) begin
                  st_next = H_IDLE;
                  done_next = 1'b1;
                  rd_data_next = data_reg;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_reg <= H_IDLE;
         q_reg <= 8'h00;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         cmd_reg <= 8'h00;
         rdop_reg <= 1'b0;
         frm_reg <= 2'h0;
         last_reg <= 2'h0;
         scl_pull_reg <= 1'b0;
         sda_pull_reg <= 1'b0;
         data_reg <= 16'h0000;
         rd_data <= 16'h0000;
         nack <= 1'b0;
         done <= 1'b0;
      end else begin
         st_reg <= st_next;
         q_reg <= q_next;
         ph_reg <= ph_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         cmd_reg <= cmd_next;
         rdop_reg <= rdop_next;
         frm_reg <= frm_next;
         last_reg <= last_next;
         scl_pull_reg <= scl_pull_next;
         sda_pull_reg <= sda_pull_next;
         data_reg <= data_next;
         rd_data <= rd_data_next;
         nack <= nack_next;
         done <= done_next;
      end
   end

   assign bus.host_scl_o = 1'b0;
   assign bus.host_scl_oe = scl_pull_reg;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe = sda_pull_reg;

endmodule

`default_nettype wire

// ---- dv/rtpm_properties.sv ----
// wire-level checks on the serial link between host and device
`default_nettype none
module rtpm_properties (
   input wire logic clk, // system clock
   input wire logic rst_b, // sync reset
   input wire logic host_scl_o, // host clock level
   input wire logic host_scl_oe, // host pulls clock
   input wire logic host_sda_o, // host data level
   input wire logic host_sda_oe, // host pulls data
   input wire logic dev_sda_o, // device data level
   input wire logic dev_sda_oe, // device pulls data
   input wire logic scl_i, // resolved clock
   input wire logic sda_i // resolved data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // idle counter: clock high long means no frame
   // ----
   logic [5:0] hi_reg;
   logic [5:0] hi_next;
   always_comb begin
      hi_next = (scl_i && hi_reg != 6'h3F) ? hi_reg + 6'h01 : (scl_i ? hi_reg : 6'h00);
   end
   always_ff @(posedge clk) begin
      hi_reg <= rst_b ? hi_next : 6'h00;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence start_cond;
      scl_i && $rose(host_sda_oe);
   endsequence
   sequence clock_pulled;
      ##[1:20] host_scl_oe;
   endsequence
   a_open_drain_only: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("serial output driven high");
   a_host_owns_clock: assert property (scl_i == !host_scl_oe)
      else $error("clock held by someone other than host");
   a_start_then_clock: assert property (start_cond |-> clock_pulled)
      else $error("no clock after start");
   a_scl_low_min: assert property ($rose(host_scl_oe) |-> host_scl_oe [*6])
      else $error("clock low too short");
   a_scl_high_min: assert property ($fell(host_scl_oe) |-> !host_scl_oe [*4])
      else $error("clock high too short");
   a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl_i && !$past(scl_i))
      else $error("device data moved with clock high");
   a_dev_holds_bit: assert property (dev_sda_oe && scl_i |=> dev_sda_oe || !scl_i)
      else $error("device bit dropped while clock high");
   // a start after a long idle pulls data first, so the clock must follow it
   a_idle_released: assert property (hi_reg > 6'd40 |->
      ((!dev_sda_oe && !host_sda_oe) or (!dev_sda_oe ##[1:20] host_scl_oe)))
      else $error("data held with bus idle");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench: host and device joined across the serial link
`default_nettype none
module tb
   import rtpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DV8 = 10, DV12 = 20, TK8 = 8, TK12 = 10;
   logic clk = 1'b0, rst_b = 1'b0, wr_req = 1'b0, rd_req = 1'b0, rd_two = 1'b0;
   logic [7:0] wr_cmd = 8'h00;
   logic [11:0] adc_data = 12'h000;
   logic ready, done, nack, busy, res8, adc_sample;
   logic [15:0] rd_data;
   logic [3:0] drv_en;
   rtpm_mux_t adc_mux;
   int miscompares = 0, samples_checked = 0, bl = 0, last_bl = 0, pulses = 0, convs = 0;
   always #20 clk = ~clk;
   rtpm_if link ();
   rtpm_host #(.QTR(4)) rtpm_host_inst (.clk(clk), .rst_b(rst_b), .bus(link), .wr_req(wr_req),
      .wr_cmd(wr_cmd), .rd_req(rd_req), .rd_two(rd_two), .ready(ready), .done(done), .nack(nack),
      .rd_data(rd_data));
   rtpm_dev #(.DIV_8(DV8), .DIV_12(DV12), .TICKS_8(TK8), .TICKS_12(TK12)) rtpm_dev_inst (.clk(clk),
      .rst_b(rst_b), .bus(link), .adc_data(adc_data), .adc_sample(adc_sample), .drv_en(drv_en),
      .adc_mux(adc_mux), .busy(busy), .res8(res8));
   rtpm_properties rtpm_properties_inst (.clk(clk), .rst_b(rst_b), .host_scl_o(link.host_scl_o),
      .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
      .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl_i(link.scl_i), .sda_i(link.sda_i));
   // conversion length, counted in clocks with busy high
   always @(posedge clk) begin
      if (adc_sample === 1'b1) begin
         pulses <= pulses + 1;
      end
      if (busy === 1'b1) begin
         bl <= bl + 1;
      end else if (bl != 0) begin
         last_bl <= bl;
         bl <= 0;
      end
   end
   // ----
   // tasks and expectations
   // ----
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // waits while sig stays at lvl; a hang is a mismatch
   task automatic wait_while(ref logic sig, input logic lvl);
      int n;
      n = 0;
      while (sig === lvl && n < 3000) begin
         @(posedge clk) #1;
         n++;
      end
      if (n >= 3000) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] cmd, input logic two);
      wr_req = w;
      rd_req = !w;
      wr_cmd = cmd;
      rd_two = two;
      @(posedge clk) #1;
      wr_req = 1'b0;
      rd_req = 1'b0;
      wait_while(done, 1'b0);
   endtask
   function automatic logic [3:0] exp_drv(input logic [3:0] f);
      return (f[1:0] == 2'h0) ? DRV_X_PLATE : (f[1:0] == 2'h1) ? DRV_Y_PLATE : DRV_CROSS;
   endfunction
   function automatic rtpm_mux_t exp_mux(input logic [3:0] f);
      return (f[1:0] == 2'h0) ? RTPM_MUX_Y_POS : (f[1:0] == 2'h3) ? RTPM_MUX_Y_NEG : RTPM_MUX_X_POS;
   endfunction
   // ----
   // main sequence
   // ----
   initial begin
      logic [3:0] fn;
      logic r;
      int unsigned seed;
      seed = $urandom(32'h0CDD);
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      check("drv_en reset", 16'(drv_en), 16'(DRV_OFF));
      check("busy reset", 16'(busy), 16'h0000);
      for (int i = 0; i < 24; i++) begin
         fn = 4'h8 | ((i < 8) ? 4'(i) : 4'($urandom));
         r = 1'($urandom);
         adc_data = 12'($urandom);
         xfer(1'b1, {fn, 2'b00, r, 1'b0}, 1'b0);
         check("nack", 16'(nack), 16'h0000);
         check("drivers", 16'(drv_en), 16'(exp_drv(fn)));
         if (fn[2]) begin
            check("mux", 16'(adc_mux), 16'(exp_mux(fn)));
            check("busy", 16'(busy), 16'h0001);
            wait_while(busy, 1'b1);
            @(posedge clk) #1;
            check("conv time", 16'(last_bl), 16'(r ? TK8 * DV8 : TK12 * DV12));
            convs++;
            check("sample pulses", 16'(pulses), 16'(convs));
            check("res8", 16'(res8), 16'(r));
            check("drivers off", 16'(drv_en), 16'(DRV_OFF));
            xfer(1'b0, 8'h00, !r);
            check("result", rd_data, r ? {8'h00, adc_data[11:4]} : {adc_data, 4'h0});
         end else begin
            // host settling delay after the drivers-only command
            repeat (60) @(posedge clk) #1;
            check("drivers held", 16'(drv_en), 16'(exp_drv(fn)));
         end
         $display("test %0d done", i);
      end
      // command with the valid bit clear is acked and ignored
      fn = drv_en;
      xfer(1'b1, 8'h70, 1'b0);
      check("ignored nack", 16'(nack), 16'h0000);
      check("ignored drv", 16'(drv_en), 16'(fn));
      $display("test invalid done");
      complete_run();
   end
endmodule
`default_nettype wire
